// ==== verilog/cafs_defines.svh ====
`ifndef CAFS_DEFINES_SVH
`define CAFS_DEFINES_SVH

// Sizes
`define CAFS_NUM_FILT      16
`define CAFS_NUM_MASK      3

// Register byte addresses
`define CAFS_ADR_FEN       8'h00
`define CAFS_ADR_PTR_A     8'h04
`define CAFS_ADR_PTR_B     8'h08
`define CAFS_ADR_PTR_C     8'h0c
`define CAFS_ADR_PTR_D     8'h10
`define CAFS_ADR_MSEL_LO   8'h14
`define CAFS_ADR_MSEL_HI   8'h18
`define CAFS_ADR_STATUS    8'h1c
`define CAFS_ADR_MASK_BASE 8'h20
`define CAFS_ADR_MASK_END  8'h38
`define CAFS_ADR_FLT_BASE  8'h40
`define CAFS_ADR_FLT_END   8'hc0

// Reset values
`define CAFS_FEN_RST       16'hffff
`define CAFS_PTR_RST       16'h0000
`define CAFS_MSEL_RST      16'h0000

// Identifier register layout
`define CAFS_SID_MSB       15
`define CAFS_SID_LSB       5
`define CAFS_TYPE_BIT      3
`define CAFS_EXTU_MSB      1
`define CAFS_SID_IMPL      16'hffeb

// Pointer value that steers to the receive FIFO
`define CAFS_PTR_FIFO      4'hf

`endif

// ==== verilog/cafs_pkg.sv ====
`include "cafs_defines.svh"

package cafs_pkg;

   typedef enum logic [1:0] {
      CAFS_MSK0 = 2'b00,
      CAFS_MSK1 = 2'b01,
      CAFS_MSK2 = 2'b10,
      CAFS_MRSV = 2'b11
   } cafs_msksrc_e;

   typedef struct packed {
      logic        valid;
      logic        ext;
      logic [10:0] sid;
      logic [17:0] eid;
   } cafs_msg_s;

   typedef struct packed {
      logic       valid;
      logic       hit;
      logic       to_fifo;
      logic [3:0] dest_buf;
      logic [3:0] filter;
   } cafs_res_s;

   typedef struct packed {
      logic [15:0]                       fen;
      logic [3:0][15:0]                  ptr;
      logic [1:0][15:0]                  msel;
      logic [`CAFS_NUM_MASK-1:0][15:0]   msid;
      logic [`CAFS_NUM_MASK-1:0][15:0]   meid;
      logic [`CAFS_NUM_FILT-1:0][15:0]   fsid;
      logic [`CAFS_NUM_FILT-1:0][15:0]   feid;
      logic                              ack;
      logic [31:0]                       rdat;
      cafs_res_s                         res;
      logic [9:0]                        last;
   } cafs_state_s;

endpackage

// ==== verilog/cafs_match.sv ====
`timescale 1ns/1ps
`include "cafs_defines.svh"

module cafs_match (
   // Configuration
   input  wire logic [15:0]                     fen_i,
   input  wire logic [31:0]                     msel_i,
   input  wire logic [`CAFS_NUM_MASK-1:0][15:0] msid_i,
   input  wire logic [`CAFS_NUM_MASK-1:0][15:0] meid_i,
   input  wire logic [`CAFS_NUM_FILT-1:0][15:0] fsid_i,
   input  wire logic [`CAFS_NUM_FILT-1:0][15:0] feid_i,
   // Message
   input  wire cafs_pkg::cafs_msg_s             msg_i,
   // Result
   output logic      [`CAFS_NUM_FILT-1:0]       hit_o
);

   genvar g;
   generate
      for (g = 0; g < `CAFS_NUM_FILT; g++) begin : g_filt
         cafs_pkg::cafs_msksrc_e src;
         logic [1:0]             midx;
         logic [15:0]            m_s;
         logic [15:0]            m_e;
         logic                   src_ok;
         logic                   std_ok;
         logic                   ext_ok;
         logic                   type_ok;
         assign src     = cafs_pkg::cafs_msksrc_e'(msel_i[2*g +: 2]);
         assign src_ok  = (src != cafs_pkg::CAFS_MRSV);
         // Reserved source is steered to mask 0 only to keep the index in range
         assign midx    = src_ok ? msel_i[2*g +: 2] : 2'b00;
         assign m_s     = msid_i[midx];
         assign m_e     = meid_i[midx];
         assign std_ok  = ~|((msg_i.sid ^ fsid_i[g][`CAFS_SID_MSB:`CAFS_SID_LSB])
                            & m_s[`CAFS_SID_MSB:`CAFS_SID_LSB]);
         assign ext_ok  = ~|((msg_i.eid ^ {fsid_i[g][`CAFS_EXTU_MSB:0], feid_i[g]})
                            & {m_s[`CAFS_EXTU_MSB:0], m_e});
         assign type_ok = ~m_s[`CAFS_TYPE_BIT]
                          | (msg_i.ext == fsid_i[g][`CAFS_TYPE_BIT]);
         // Standard frames carry no extended bits, so those are not compared
         assign hit_o[g] = fen_i[g] & src_ok & std_ok & type_ok
                           & (~msg_i.ext | ext_ok);
      end
   endgenerate

endmodule

// ==== verilog/cafs_top.sv ====
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "cafs_defines.svh"


module cafs_top (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [31:0]         wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   // Message from the protocol engine
   input  wire cafs_pkg::cafs_msg_s msg_i,
   // Steering result
   output cafs_pkg::cafs_res_s      res_o
);

   cafs_pkg::cafs_state_s    q;
   cafs_pkg::cafs_state_s    d;
   logic [`CAFS_NUM_FILT-1:0] hit;
   logic                     req;
   logic                     hi_zero;
   logic                     in_flt;
   logic                     in_msk;
   logic [7:0]               fofs;
   logic [7:0]               mofs;
   logic [3:0]               fidx;
   logic [1:0]               midx;
   logic [15:0]              rd;
   logic [15:0]              wv;
   logic [3:0]               win;
   logic                     any;
   int                       i;

   cafs_match u_match (
      .fen_i  (q.fen),
      .msel_i (q.msel),
      .msid_i (q.msid),
      .meid_i (q.meid),
      .fsid_i (q.fsid),
      .feid_i (q.feid),
      .msg_i  (msg_i),
      .hit_o  (hit)
   );

   // Merge write data into a 16-bit register honouring the two low byte lanes
   function automatic logic [15:0] lanes(input logic [15:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction

   always_comb begin
      d       = q;
      d.ack   = 1'b0;
      d.res.valid = 1'b0;
      req     = wb_cyc_i & wb_stb_i & ~q.ack;
      hi_zero = ~|wb_adr_i[31:8];
      fofs    = wb_adr_i[7:0] - `CAFS_ADR_FLT_BASE;
      mofs    = wb_adr_i[7:0] - `CAFS_ADR_MASK_BASE;
      fidx    = fofs[6:3];
      midx    = mofs[4:3];
      in_flt  = hi_zero && (wb_adr_i[1:0] == 2'b00)
                && (wb_adr_i[7:0] >= `CAFS_ADR_FLT_BASE)
                && (wb_adr_i[7:0] < `CAFS_ADR_FLT_END);
      in_msk  = hi_zero && (wb_adr_i[1:0] == 2'b00)
                && (wb_adr_i[7:0] >= `CAFS_ADR_MASK_BASE)
                && (wb_adr_i[7:0] < `CAFS_ADR_MASK_END);

      // Read mux; unmapped addresses answer with zero
      rd = 16'h0000;
      if (in_flt) begin
         rd = fofs[2] ? q.feid[fidx] : q.fsid[fidx];
      end else if (in_msk) begin
         rd = mofs[2] ? q.meid[midx] : q.msid[midx];
      end else if (hi_zero) begin
         case (wb_adr_i[7:0])
            `CAFS_ADR_FEN:     rd = q.fen;
            `CAFS_ADR_PTR_A:   rd = q.ptr[0];
            `CAFS_ADR_PTR_B:   rd = q.ptr[1];
            `CAFS_ADR_PTR_C:   rd = q.ptr[2];
            `CAFS_ADR_PTR_D:   rd = q.ptr[3];
            `CAFS_ADR_MSEL_LO: rd = q.msel[0];
            `CAFS_ADR_MSEL_HI: rd = q.msel[1];
            `CAFS_ADR_STATUS:  rd = {6'h00, q.last};
            default:           rd = 16'h0000;
         endcase
      end
      if (req) begin
         d.ack  = 1'b1;
         d.rdat = {16'h0000, rd};
      end

      // Writes take effect on the acknowledging edge
      wv = 16'h0000;
      if (req && wb_we_i) begin
         if (in_flt) begin
            if (fofs[2]) begin
               d.feid[fidx] = lanes(q.feid[fidx], wb_dat_i, wb_sel_i);
            end else begin
               wv = lanes(q.fsid[fidx], wb_dat_i, wb_sel_i);
               d.fsid[fidx] = wv & `CAFS_SID_IMPL;
            end
         end else if (in_msk) begin
            if (mofs[2]) begin
               d.meid[midx] = lanes(q.meid[midx], wb_dat_i, wb_sel_i);
            end else begin
               wv = lanes(q.msid[midx], wb_dat_i, wb_sel_i);
               d.msid[midx] = wv & `CAFS_SID_IMPL;
            end
         end else if (hi_zero) begin
            case (wb_adr_i[7:0])
               `CAFS_ADR_FEN:     d.fen     = lanes(q.fen, wb_dat_i, wb_sel_i);
               `CAFS_ADR_PTR_A:   d.ptr[0]  = lanes(q.ptr[0], wb_dat_i, wb_sel_i);
               `CAFS_ADR_PTR_B:   d.ptr[1]  = lanes(q.ptr[1], wb_dat_i, wb_sel_i);
               `CAFS_ADR_PTR_C:   d.ptr[2]  = lanes(q.ptr[2], wb_dat_i, wb_sel_i);
               `CAFS_ADR_PTR_D:   d.ptr[3]  = lanes(q.ptr[3], wb_dat_i, wb_sel_i);
               `CAFS_ADR_MSEL_LO: d.msel[0] = lanes(q.msel[0], wb_dat_i, wb_sel_i);
               `CAFS_ADR_MSEL_HI: d.msel[1] = lanes(q.msel[1], wb_dat_i, wb_sel_i);
               default: begin
               end
            endcase
         end
      end

      // Lowest-numbered hit wins, so scan from the top down
      win = 4'h0;
      any = 1'b0;
      for (i = `CAFS_NUM_FILT - 1; i >= 0; i--) begin
         if (hit[i]) begin
            win = 4'(i);
            any = 1'b1;
         end
      end
      if (msg_i.valid) begin
         d.res.valid    = 1'b1;
         d.res.hit      = any;
         d.res.filter   = win;
         // Pointer of filter n sits at bits 4n+3..4n of the flat group registers
         d.res.to_fifo  = any && (q.ptr[win[3:2]][4*win[1:0] +: 4] == `CAFS_PTR_FIFO);
         d.res.dest_buf = any ? q.ptr[win[3:2]][4*win[1:0] +: 4] : 4'h0;
         d.last         = {d.res.to_fifo, d.res.hit, d.res.filter, d.res.dest_buf};
      end

      // Identifier and mask contents are deliberately left untouched by reset
      if (rst_i) begin
         d.fen  = `CAFS_FEN_RST;
         d.ptr  = {4{`CAFS_PTR_RST}};
         d.msel = {2{`CAFS_MSEL_RST}};
         d.fsid = q.fsid;
         d.feid = q.feid;
         d.msid = q.msid;
         d.meid = q.meid;
         d.ack  = 1'b0;
         d.rdat = 32'h0000_0000;
         d.res  = '0;
         d.last = 10'h000;
      end
   end

   always_ff @(posedge clk_i) begin
      q <= d;
   end

   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign res_o    = q.res;

endmodule

// ==== testbench/cafs_assertions.sv ====
`timescale 1ns/1ps
module cafs_assertions (
   // Clock and bus
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                wb_cyc_i,
   input wire logic                wb_stb_i,
   input wire logic                wb_we_i,
   input wire logic [31:0]         wb_adr_i,
   input wire logic [31:0]         wb_dat_o,
   input wire logic                wb_ack_o,
   // Message path
   input wire cafs_pkg::cafs_msg_s msg_i,
   input wire cafs_pkg::cafs_res_s res_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_sid_rd;
      s_req and (!wb_we_i && wb_adr_i >= 32'h40 && wb_adr_i < 32'hc0
                 && wb_adr_i[2:0] == 3'h0);
   endsequence
   property p_ack;
      s_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a pulse after request");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_res_timing;
      res_o.valid == $past(msg_i.valid);
   endproperty
   a_res_timing: assert property (p_res_timing) else $error("result timing wrong");
   property p_nohit_zero;
      res_o.valid && !res_o.hit |-> {res_o.to_fifo, res_o.dest_buf, res_o.filter} == 9'h000;
   endproperty
   a_nohit_zero: assert property (p_nohit_zero) else $error("miss fields not zero");
   property p_fifo;
      res_o.valid && res_o.hit |-> res_o.to_fifo == (res_o.dest_buf == 4'hf);
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo flag disagrees with pointer");
   property p_hold;
      !msg_i.valid |=> $stable(res_o.hit) && $stable(res_o.filter) && $stable(res_o.dest_buf);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed without message");
   property p_sid_zero;
      s_sid_rd |=> wb_dat_o[4] == 1'b0 && wb_dat_o[2] == 1'b0;
   endproperty
   a_sid_zero: assert property (p_sid_zero) else $error("unimplemented bits read set");
   property p_reset;
      $fell(rst_i) |-> !wb_ack_o && res_o == '0;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule

// ==== testbench/cafs_engine_model.sv ====
`timescale 1ns/1ps
module cafs_engine_model (
   // Clock and message out
   input  wire logic          clk_i,
   output cafs_pkg::cafs_msg_s msg_o
);
   initial msg_o = '0;
   task automatic send(input logic e, input logic [10:0] s, input logic [17:0] x);
      msg_o <= {1'b1, e, s, x};
      @(posedge clk_i);
      // Stale ids are inverted so nothing relies on them after the pulse
      msg_o <= {1'b0, ~e, ~s, ~x};
   endtask
endmodule

// ==== testbench/tb_cafs_top.sv ====
`timescale 1ns/1ps
module tb_cafs_top;
   logic                clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [31:0]         wb_adr_i, wb_dat_i, wb_dat_o, q, fl;
   logic [3:0]          wb_sel_i, sel_v;
   logic [15:0]         rm [0:63];
   cafs_pkg::cafs_msg_s msg;
   cafs_pkg::cafs_res_s res_o, er;
   int                  num_errors, checks, seed, f;
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   cafs_top u_cafs_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .msg_i(msg), .res_o(res_o));
   cafs_engine_model u_cafs_engine_model (.clk_i(clk_i), .msg_o(msg));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic print_verdict;
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input int i, input logic [15:0] d);
      logic [15:0] m;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= 32'(i) << 2;
      wb_dat_i <= {16'h0000, d};
      wb_sel_i <= sel_v;
      // Only the acknowledge or, failing it, the watchdog ends this wait
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
      // Byte lanes 0 and 1 each carry one half of a 16-bit register
      m = {{8{sel_v[1]}}, {8{sel_v[0]}}};
      if (we && i < 48) rm[i] = (rm[i] & ~m) | (d & m);
      if (we && i >= 8 && i < 48 && i % 2 == 0) rm[i] = rm[i] & 16'hffeb;
   endtask
   task automatic rdc(input int i, input logic [15:0] e);
      wb(1'b0, i, 16'h0000);
      chk($sformatf("reg %0d", i), {16'h0000, e}, q);
   endtask
   function automatic cafs_pkg::cafs_res_s exp_res(input logic e, input logic [10:0] s,
                                                  input logic [17:0] x);
      cafs_pkg::cafs_res_s r;
      logic [15:0]         fs, ms;
      logic [1:0]          src;
      logic                ok;
      logic [17:0]         xm;
      r = '0;
      r.valid = 1'b1;
      // Walking down leaves the lowest matching filter in r
      for (int n = 15; n >= 0; n--) begin
         src = rm[5 + n / 8][2 * (n % 8) +: 2];
         fs = rm[16 + 2 * n];
         ms = rm[8 + 2 * src];
         ok = rm[0][n] && src != 2'b11;
         if (((s ^ fs[15:5]) & ms[15:5]) != 11'h000) ok = 1'b0;
         if (ms[3] && fs[3] != e) ok = 1'b0;
         xm = {ms[1:0], rm[9 + 2 * src]};
         if (e && (({fs[1:0], rm[17 + 2 * n]} ^ x) & xm) != 18'h0) ok = 1'b0;
         if (ok) begin
            r.hit = 1'b1;
            r.filter = 4'(n);
            r.dest_buf = rm[1 + n / 4][4 * (n % 4) +: 4];
            r.to_fifo = r.dest_buf == 4'hf;
         end
      end
      return r;
   endfunction
   task automatic send_chk(input logic e, input logic [10:0] s, input logic [17:0] x);
      er = exp_res(e, s, x);
      u_cafs_engine_model.send(e, s, x);
      @(posedge clk_i);
      chk("result", 32'(er), 32'(res_o));
   endtask
   initial begin
      seed = 32'hab4052bb;
      num_errors = 0;
      checks = 0;
      sel_v = 4'h3;
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) rdc(i, i == 0 ? 16'hffff : 16'h0000);
      wb(1'b1, 50, 16'h1234);
      rdc(50, 16'h0000);
      for (int i = 0; i < 48; i++) begin
         if (i != 7 && i != 14 && i != 15) wb(1'b1, i, 16'($random(seed)));
      end
      for (int i = 0; i < 48; i++) begin
         if (i != 7 && i != 14 && i != 15) rdc(i, rm[i]);
      end
      // A single-lane write must leave the other byte of the register alone
      for (int k = 1; k < 3; k++) begin
         sel_v = 4'(k);
         wb(1'b1, 16 + 2 * k, 16'($random(seed)));
         rdc(16 + 2 * k, rm[16 + 2 * k]);
      end
      sel_v = 4'h3;
      wb(1'b1, 0, 16'h0000);
      send_chk(1'b0, rm[16][15:5], 18'h00000);
      wb(1'b1, 0, 16'hffff);
      wb(1'b1, 1, 16'hffff);
      for (int i = 0; i < 300; i++) begin
         if (i % 8 == 7) wb(1'b1, {$random(seed)} % 7, 16'($random(seed)));
         f = {$random(seed)} % 16;
         // Sparse flips keep hits frequent while still exercising misses
         fl = $random(seed) & $random(seed) & $random(seed);
         send_chk(1'($random(seed)), rm[16 + 2 * f][15:5] ^ fl[10:0],
                  {rm[16 + 2 * f][1:0], rm[17 + 2 * f]} ^ fl[28:11]);
         if (i % 4 == 0) rdc(7, {6'h00, er.to_fifo, er.hit, er.filter, er.dest_buf});
         repeat ({$random(seed)} % 3) @(posedge clk_i);
      end
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      print_verdict();
   end
endmodule
bind cafs_top cafs_assertions u_cafs_assertions (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .msg_i(msg_i), .res_o(res_o));
